// >>> core/sef_front.sv
// Serial memory front end: pin sampling, selection, pause, shifting
`timescale 1ns/100ps
`default_nettype none
module sef_front
	import sef_pkg::*;
#(
	parameter bit ID_PAGE_EN = 1'b1
) (
	input  wire logic                 clk_in,
	input  wire logic                 resetn_in,
	input  wire logic                 factory_init_in,
	input  wire sef_pkg::sef_pins_t   pins_in,
	output var  logic                 sdo_out,
	output var  logic                 sdo_oe_out,
	output var  logic                 standby_out,
	output var  logic                 active_out,
	input  wire logic [sef_pkg::REG_AW-1:0] addr_in,
	input  wire logic [sef_pkg::REG_DW-1:0] wdata_in,
	input  wire logic                 wr_in,
	input  wire logic                 rd_in,
	output var  logic [sef_pkg::REG_DW-1:0] rdata_out
);
	import sef_pkg::*;

	generate
		if (ARRAY_DEPTH != (1 << ARRAY_AW)) begin : g_chk_arr
			$error("Array depth and address width disagree");
		end
		if (BYTE_BITS != 8) begin : g_chk_byte
			$error("Shifter serves eight-bit bytes only");
		end
	endgenerate

	// Pin sampling
	sef_pins_t pins_s;
	sef_pins_t pins_q_ff;

	sef_sync #(
		.W   (5),
		.RST (PIN_RST)
	) u_sync (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.d_in      (pins_in),
		.q_out     (pins_s)
	);

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			pins_q_ff <= PIN_RST;
		end else begin
			pins_q_ff <= pins_s;
		end
	end

	// Edge detection on the synchronised lines
	wire sck_rise   = pins_s.sck & ~pins_q_ff.sck;
	wire sck_fall   = ~pins_s.sck & pins_q_ff.sck;
	wire sel_fall   = ~pins_s.sel_n & pins_q_ff.sel_n;
	wire sel_high   = pins_s.sel_n;
	wire pause_fall = ~pins_s.pause_n & pins_q_ff.pause_n;
	wire pause_rise = pins_s.pause_n & ~pins_q_ff.pause_n;

	// Selection and pause state
	logic selected_ff;
	logic paused_ff;

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			selected_ff <= 1'b0;
		end else if (sel_high) begin
			selected_ff <= 1'b0;
		end else if (sel_fall) begin
			selected_ff <= 1'b1;
		end
	end

	wire pause_start = selected_ff & pause_fall & ~pins_s.sck;
	wire pause_end   = pause_rise & ~pins_s.sck;

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			paused_ff <= 1'b0;
		end else if (sel_high || pause_end) begin
			paused_ff <= 1'b0;
		end else if (pause_start) begin
			paused_ff <= 1'b1;
		end
	end

	wire shift_go = selected_ff & ~paused_ff & ~sel_high;

	// Shifter
	logic [2:0] bitcnt_ff;
	logic [7:0] rx_sh_ff;
	logic [7:0] tx_sh_ff;
	logic [7:0] rx_data_ff;
	logic [7:0] tx_hold_ff;
	logic       rx_full_ff;
	logic       ovrun_ff;
	logic       tx_empty_ff;
	logic       sdo_ff;
	logic       tx_en_ff;

	wire       rx_take   = shift_go & sck_rise;
	wire       tx_step   = shift_go & sck_fall;
	wire       byte_done = rx_take & (bitcnt_ff == 3'h7);
	wire       tx_load   = (tx_step & (bitcnt_ff == 3'h0)) | sel_fall;
	wire [7:0] rx_next   = {rx_sh_ff[6:0], pins_s.sdi};

	always_ff @(posedge clk_in) begin
		if (!resetn_in || sel_high) begin
			bitcnt_ff <= 3'h0;
			rx_sh_ff  <= 8'h00;
		end else if (rx_take) begin
			bitcnt_ff <= bitcnt_ff + 3'h1;
			rx_sh_ff  <= rx_next;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			tx_sh_ff <= TX_INIT;
			sdo_ff   <= 1'b1;
		end else if (tx_load) begin
			tx_sh_ff <= tx_hold_ff;
			sdo_ff   <= tx_hold_ff[7];
		end else if (tx_step) begin
			tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
			sdo_ff   <= tx_sh_ff[6];
		end
	end

	// Register decode
	wire sel_ctrl   = (addr_in == REG_CTRL);
	wire sel_status = (addr_in == REG_STATUS);
	wire sel_rxdata = (addr_in == REG_RXDATA);
	wire sel_txdata = (addr_in == REG_TXDATA);
	wire sel_araddr = (addr_in == REG_ARADDR);
	wire sel_flags  = (addr_in == REG_FLAGS);
	wire sel_idaddr = (addr_in == REG_IDADDR);
	wire sel_iddata = (addr_in == REG_IDDATA);
	wire sel_idlock = (addr_in == REG_IDLOCK);

	wire wr_ctrl   = wr_in & sel_ctrl;
	wire wr_status = wr_in & sel_status;
	wire wr_txdata = wr_in & sel_txdata;
	wire wr_araddr = wr_in & sel_araddr;
	wire wr_idaddr = wr_in & sel_idaddr;
	wire wr_iddata = wr_in & sel_iddata;
	wire wr_idlock = wr_in & sel_idlock;
	wire rd_rxdata = rd_in & sel_rxdata;

	// Receive data and flags; a hardware set of rx_full wins over a read clear, while a read clears ovrun even as a byte completes
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			rx_data_ff <= 8'h00;
			rx_full_ff <= 1'b0;
			ovrun_ff   <= 1'b0;
		end else begin
			if (byte_done) begin
				rx_data_ff <= rx_next;
			end
			rx_full_ff <= byte_done | (rx_full_ff & ~rd_rxdata);
			ovrun_ff   <= (byte_done & rx_full_ff & ~rd_rxdata) |
			              (ovrun_ff & ~rd_rxdata);
		end
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			tx_hold_ff  <= TX_INIT;
			tx_empty_ff <= 1'b1;
			tx_en_ff    <= 1'b0;
		end else begin
			if (wr_txdata) begin
				tx_hold_ff <= wdata_in[7:0];
			end
			if (wr_ctrl) begin
				tx_en_ff <= wdata_in[CT_TXEN];
			end
			tx_empty_ff <= (tx_load & selected_ff) |
			               (tx_empty_ff & ~wr_txdata);
		end
	end

	// Status: volatile part
	sef_stat_t stat;
	logic      busy_ff;
	logic      wel_ff;
	logic      swd_ff;
	logic [1:0] prot_ff;

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			busy_ff <= 1'b0;
			wel_ff  <= 1'b0;
		end else if (wr_status) begin
			busy_ff <= wdata_in[ST_BUSY];
			wel_ff  <= wdata_in[ST_WEL];
		end
	end

	// Status: non-volatile part, untouched by the power-on reset
	always_ff @(posedge clk_in) begin
		if (factory_init_in) begin
			swd_ff  <= NV_SWD_INIT;
			prot_ff <= NV_PROT_INIT;
		end else if (resetn_in && wr_status) begin
			swd_ff <= wdata_in[ST_SWD];
			if (pins_s.wprot_n) begin
				prot_ff <= wdata_in[ST_PHI:ST_PLO];
			end
		end
	end

	assign stat = '{swd: swd_ff, prot: prot_ff, write_enable_latch: wel_ff,
	                busy: busy_ff};

	// Array address and protected-region check
	logic [ARRAY_AW-1:0] araddr_ff;

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			araddr_ff <= '0;
		end else if (wr_araddr) begin
			araddr_ff <= wdata_in[ARRAY_AW-1:0];
		end
	end

	wire addr_prot = (stat.prot == 2'h3) |
	                 ((stat.prot == 2'h2) & (araddr_ff >= PROT_H_BASE)) |
	                 ((stat.prot == 2'h1) & (araddr_ff >= PROT_Q_BASE));

	// Identification page
	logic [ID_AW-1:0] idaddr_ff;
	logic             idlock_ff;
	logic [7:0]       id_q;

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			idaddr_ff <= '0;
		end else if (wr_idaddr) begin
			idaddr_ff <= wdata_in[ID_AW-1:0];
		end
	end

	always_ff @(posedge clk_in) begin
		if (factory_init_in) begin
			idlock_ff <= NV_LOCK_INIT;
		end else if (resetn_in && wr_idlock && wdata_in[0]) begin
			idlock_ff <= 1'b1;
		end
	end

	wire id_we = wr_iddata & ~idlock_ff & ID_PAGE_EN & resetn_in;

	sef_id_mem #(
		.DEPTH (ID_DEPTH),
		.AW    (ID_AW),
		.W     (BYTE_BITS)
	) u_idmem (
		.clk_in    (clk_in),
		.we_in     (id_we),
		.waddr_in  (idaddr_ff),
		.wdata_in  (wdata_in[7:0]),
		.raddr_in  (idaddr_ff),
		.rdata_out (id_q)
	);

	// Read multiplexer
	logic [7:0] flags;
	logic [7:0] stat_byte;
	logic [REG_DW-1:0] rd_mux;

	always_comb begin
		flags             = 8'h00;
		flags[FL_SEL]     = selected_ff;
		flags[FL_PAUSE]   = paused_ff;
		flags[FL_RXFULL]  = rx_full_ff;
		flags[FL_OVRUN]   = ovrun_ff;
		flags[FL_TXEMPT]  = tx_empty_ff;
		flags[FL_APROT]   = addr_prot;
		flags[FL_WPN]     = pins_s.wprot_n;
		flags[FL_IDLOCK]  = idlock_ff;
		stat_byte         = 8'h00;
		stat_byte[ST_BUSY] = stat.busy;
		stat_byte[ST_WEL]  = stat.write_enable_latch;
		stat_byte[ST_PHI:ST_PLO] = stat.prot;
		stat_byte[ST_SWD]  = stat.swd;
	end

	always_comb begin
		rd_mux = '0;
		unique case (1'b1)
			sel_ctrl:   rd_mux[0] = tx_en_ff;
			sel_status: rd_mux[7:0] = stat_byte;
			sel_rxdata: rd_mux[7:0] = rx_data_ff;
			sel_txdata: rd_mux[7:0] = tx_hold_ff;
			sel_araddr: rd_mux[ARRAY_AW-1:0] = araddr_ff;
			sel_flags:  rd_mux[7:0] = flags;
			sel_idaddr: rd_mux[ID_AW-1:0] = idaddr_ff;
			sel_iddata: rd_mux[7:0] = ID_PAGE_EN ? id_q : 8'h00;
			sel_idlock: rd_mux[0] = idlock_ff;
			default:    rd_mux = '0;
		endcase
	end

	// Registered outputs
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			rdata_out   <= '0;
			sdo_out     <= 1'b1;
			sdo_oe_out  <= 1'b0;
			standby_out <= 1'b1;
			active_out  <= 1'b0;
		end else begin
			rdata_out   <= rd_in ? rd_mux : '0;
			sdo_out     <= sdo_ff;
			sdo_oe_out  <= shift_go & tx_en_ff;
			standby_out <= ~selected_ff & ~busy_ff;
			active_out  <= selected_ff;
		end
	end
endmodule
`default_nettype wire

// >>> core/sef_id_mem.sv
// Identification page store with registered read data
`timescale 1ns/100ps
`default_nettype none
module sef_id_mem #(
	parameter int DEPTH = 64,
	parameter int AW    = 6,
	parameter int W     = 8
) (
	input  wire logic          clk_in,
	input  wire logic          we_in,
	input  wire logic [AW-1:0] waddr_in,
	input  wire logic [W-1:0]  wdata_in,
	input  wire logic [AW-1:0] raddr_in,
	output var  logic [W-1:0]  rdata_out
);
	logic [W-1:0] mem [DEPTH];

	generate
		if (DEPTH > (1 << AW)) begin : g_chk
			$error("Depth exceeds address range");
		end
	endgenerate

	always_ff @(posedge clk_in) begin
		if (we_in) begin
			mem[waddr_in] <= wdata_in;
		end
		rdata_out <= mem[raddr_in];
	end
endmodule
`default_nettype wire

// >>> core/sef_pkg.sv
// Shared constants and types of the serial memory front end
package sef_pkg;

	localparam int REG_AW = 8;
	localparam int REG_DW = 32;

	// Register byte addresses
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_RXDATA = 8'h08;
	localparam logic [7:0] REG_TXDATA = 8'h0c;
	localparam logic [7:0] REG_ARADDR = 8'h10;
	localparam logic [7:0] REG_FLAGS  = 8'h14;
	localparam logic [7:0] REG_IDADDR = 8'h18;
	localparam logic [7:0] REG_IDDATA = 8'h1c;
	localparam logic [7:0] REG_IDLOCK = 8'h20;

	// Status field positions
	localparam int ST_BUSY = 0;
	localparam int ST_WEL  = 1;
	localparam int ST_PLO  = 2;
	localparam int ST_PHI  = 3;
	localparam int ST_SWD  = 7;

	// Flags field positions
	localparam int FL_SEL    = 0;
	localparam int FL_PAUSE  = 1;
	localparam int FL_RXFULL = 2;
	localparam int FL_OVRUN  = 3;
	localparam int FL_TXEMPT = 4;
	localparam int FL_APROT  = 5;
	localparam int FL_WPN    = 6;
	localparam int FL_IDLOCK = 7;

	// Control field positions
	localparam int CT_TXEN = 0;

	// Reset and factory values
	localparam logic       NV_SWD_INIT  = 1'b0;
	localparam logic [1:0] NV_PROT_INIT = 2'b00;
	localparam logic       NV_LOCK_INIT = 1'b0;
	localparam logic [7:0] TX_INIT      = 8'hff;

	// Array and page geometry
	localparam int BYTE_BITS   = 8;
	localparam int ARRAY_DEPTH = 32768;
	localparam int ARRAY_AW    = 15;
	localparam int ID_DEPTH    = 64;
	localparam int ID_AW       = 6;

	// Protected region bases
	localparam logic [14:0] PROT_Q_BASE = 15'h6000;
	localparam logic [14:0] PROT_H_BASE = 15'h4000;

	// Reset level of each synchronised pin: select low so a held-low
	// line shows no falling edge after reset
	localparam logic [4:0] PIN_RST = 5'h03;

	typedef struct packed {
		logic sel_n;
		logic sck;
		logic sdi;
		logic pause_n;
		logic wprot_n;
	} sef_pins_t;

	typedef struct packed {
		logic       swd;
		logic [1:0] prot;
		logic       write_enable_latch;
		logic       busy;
	} sef_stat_t;

endpackage

// >>> core/sef_sync.sv
// Two-stage synchroniser, one per bit
`timescale 1ns/100ps
`default_nettype none
module sef_sync #(
	parameter int              W   = 5,
	parameter logic [W-1:0]    RST = '0
) (
	input  wire logic          clk_in,
	input  wire logic          resetn_in,
	input  wire logic [W-1:0]  d_in,
	output var  logic [W-1:0]  q_out
);
	logic [W-1:0] meta_ff;

	generate
		for (genvar i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk_in) begin
				if (!resetn_in) begin
					meta_ff[i] <= RST[i];
					q_out[i]   <= RST[i];
				end else begin
					meta_ff[i] <= d_in[i];
					q_out[i]   <= meta_ff[i];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// >>> verification/sef_front_assertions.sv
// Port checker of the serial memory front end
`timescale 1ns/100ps
`default_nettype none
module sef_front_chk (
	input wire logic               clk_in,
	input wire logic               resetn_in,
	input wire sef_pkg::sef_pins_t pins_in,
	input wire logic               sdo_out,
	input wire logic               sdo_oe_out,
	input wire logic               standby_out,
	input wire logic               active_out
);
	import sef_pkg::*;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	sequence pause_taken;
		$fell(pins_in.pause_n) && !pins_in.sck && !pins_in.sel_n;
	endsequence
	sequence pause_held;
		(!pins_in.pause_n)[*5];
	endsequence
	chk_oe_needs_sel: assert property (sdo_oe_out |-> active_out)
		else $error("output enabled while deselected");
	chk_desel_idle: assert property (pins_in.sel_n[*6] |->
		!active_out && !sdo_oe_out)
		else $error("still selected with select high");
	chk_desel_fast: assert property ($rose(pins_in.sel_n) |->
		##[1:5] !active_out)
		else $error("deselect not seen in time");
	chk_standby_excl: assert property (active_out |-> !standby_out)
		else $error("standby while active");
	chk_reset_state: assert property (disable iff (1'b0)
		!resetn_in |=> !active_out && standby_out && !sdo_oe_out)
		else $error("wrong state after reset");
	chk_sdo_after_fall: assert property (sdo_oe_out &&
		$past(sdo_oe_out) && $changed(sdo_out) |->
		!$past(pins_in.sck, 3) || !$past(pins_in.sck, 4) ||
		!$past(pins_in.sck, 5))
		else $error("output bit changed without clock fall");
	chk_pause_quiet: assert property (pause_taken ##1 pause_held |->
		!sdo_oe_out)
		else $error("output driven while paused");
	chk_sel_edge: assert property ($rose(active_out) |->
		$past(pins_in.sel_n, 4) || $past(pins_in.sel_n, 5) ||
		$past(pins_in.sel_n, 6))
		else $error("selected without select falling edge");
endmodule
bind sef_front sef_front_chk chk_i (
	.clk_in      (clk_in),
	.resetn_in   (resetn_in),
	.pins_in     (pins_in),
	.sdo_out     (sdo_out),
	.sdo_oe_out  (sdo_oe_out),
	.standby_out (standby_out),
	.active_out  (active_out)
);
`default_nettype wire

// >>> verification/sef_spi_master.sv
// Behavioural serial bus master facing the front end
`timescale 1ns/100ps
`default_nettype none
module sef_spi_master (
	input  wire logic               sdo_in,
	output var  sef_pkg::sef_pins_t pins_out
);
	import sef_pkg::*;
	// Select starts low: the device must wait for a falling edge
	initial pins_out = 5'b00011;
	task sel(input logic v);
		pins_out.sel_n = v;
		#200;
	endtask
	task pause(input logic v);
		pins_out.pause_n = v;
		#200;
	endtask
	task wp(input logic v);
		pins_out.wprot_n = v;
		#200;
	endtask
	task xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 0; i < n; i++) begin
			pins_out.sdi = tx[7-i];
			#100 pins_out.sck = 1'b1;
			#99 rx = {rx[6:0], sdo_in};
			#1 pins_out.sck = 1'b0;
		end
		pins_out.sdi = ~pins_out.sdi;
	endtask
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench of the serial memory front end
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import sef_pkg::*;
	logic              clk_in, resetn_in, factory_init_in, wr_in, rd_in;
	logic [REG_AW-1:0] addr_in;
	logic [REG_DW-1:0] wdata_in, rdata_out, rv;
	logic              sdo_out, sdo_oe_out, standby_out, active_out;
	logic [7:0]        rx;
	sef_pins_t         pins;
	wire logic         sdo_line;
	int                fails, num_checks;
	assign sdo_line = sdo_oe_out ? sdo_out : 1'bz;
	sef_front DUT (.clk_in(clk_in), .resetn_in(resetn_in),
		.factory_init_in(factory_init_in), .pins_in(pins),
		.sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out),
		.standby_out(standby_out), .active_out(active_out),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
		.rd_in(rd_in), .rdata_out(rdata_out));
	sef_spi_master m (.sdo_in(sdo_line), .pins_out(pins));
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	task chk(input logic [31:0] v, input logic [31:0] e, input string s);
		num_checks++;
		if (v !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", s, e, v);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 rv = rdata_out;
	endtask
	task results;
		if (fails == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task wait_act(input logic v);
		for (int i = 0; i < 40 && active_out !== v; i++)
			@(posedge clk_in);
		if (active_out !== v) begin
			fails++;
			results();
		end
	endtask
	initial begin
		resetn_in = 1'b0;
		factory_init_in = 1'b1;
		addr_in = '0;
		wdata_in = '0;
		wr_in = 1'b0;
		rd_in = 1'b0;
		repeat (12) @(posedge clk_in);
		resetn_in <= 1'b1;
		factory_init_in <= 1'b0;
		m.xfer(8'h3c, 8, rx);
		chk(active_out, 1'b0, "active");
		rd(REG_FLAGS);
		chk(rv[FL_RXFULL], 1'b0, "rx_full");
		m.sel(1'b1);
		chk({active_out, standby_out, sdo_oe_out}, 3'b010, "idle");
		rd(REG_STATUS);
		chk(rv, 32'h0, "status");
		wr(REG_CTRL, 32'h1);
		wr(REG_TXDATA, 32'ha5);
		m.sel(1'b0);
		wait_act(1'b1);
		chk({standby_out, sdo_oe_out}, 2'b01, "active pins");
		m.xfer(8'h3c, 8, rx);
		chk(rx, 8'ha5, "serial out");
		rd(REG_RXDATA);
		chk(rv, 32'h3c, "rxdata");
		m.xfer(8'h96, 4, rx);
		m.pause(1'b0);
		chk(sdo_oe_out, 1'b0, "paused oe");
		m.xfer(8'hff, 4, rx);
		m.pause(1'b1);
		m.xfer(8'h60, 4, rx);
		rd(REG_RXDATA);
		chk(rv, 32'h96, "paused byte");
		m.xfer(8'h00, 3, rx);
		m.pause(1'b0);
		m.sel(1'b1);
		m.pause(1'b1);
		m.sel(1'b0);
		m.xfer(8'h5a, 8, rx);
		rd(REG_RXDATA);
		chk(rv, 32'h5a, "after abort");
		m.sel(1'b1);
		m.wp(1'b0);
		wr(REG_STATUS, 32'h0c);
		rd(REG_STATUS);
		chk(rv, 32'h00, "frozen prot");
		m.wp(1'b1);
		wr(REG_STATUS, 32'h0d);
		rd(REG_STATUS);
		chk(rv, 32'h0d, "prot");
		chk(standby_out, 1'b0, "busy standby");
		wr(REG_ARADDR, 32'hffff);
		rd(REG_ARADDR);
		chk(rv, 32'h7fff, "array addr");
		rd(8'h24);
		chk(rv, 32'h0, "unmapped");
		wr(REG_IDADDR, 32'h3f);
		wr(REG_IDDATA, 32'h77);
		rd(REG_IDDATA);
		chk(rv, 32'h77, "id data");
		wr(REG_IDLOCK, 32'h1);
		wr(REG_IDDATA, 32'h11);
		rd(REG_IDDATA);
		chk(rv, 32'h77, "locked id");
		wr(REG_STATUS, 32'h0e);
		resetn_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		resetn_in <= 1'b1;
		rd(REG_STATUS);
		chk(rv, 32'h0c, "status after reset");
		@(posedge clk_in);
		factory_init_in <= 1'b1;
		@(posedge clk_in);
		factory_init_in <= 1'b0;
		rd(REG_STATUS);
		chk(rv, 32'h0, "status after init");
		rd(REG_IDLOCK);
		chk(rv, 32'h0, "lock after init");
		results();
	end
endmodule
`default_nettype wire
